/* File: core/ecph_bus_cycle.sv */
// I/O read and write cycle engine toward the port's register pins
`timescale 1ns/1ps
`default_nettype none
module ecph_bus_cycle
   import ecph_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   ecph_cyc_if.slave cyc,
   output logic [15:0] io_addr,
   output logic [7:0] io_wdata,
   output logic io_data_oe,
   input wire logic [7:0] io_data_in,
   output logic io_rd_n,
   output logic io_wr_n
);
   ecph_cst_t cst;
   logic [3:0] cnt;
   logic we_q;
   logic done_q;
   logic [7:0] rdata_q;
   logic [7:0] data_s1;
   logic [7:0] data_s2;
   assign cyc.done = done_q;
   assign cyc.rdata = rdata_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         data_s1 <= 8'h00;
         data_s2 <= 8'h00;
      end else begin
         data_s1 <= io_data_in;
         data_s2 <= data_s1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cst <= C_IDLE;
         cnt <= 4'h0;
         we_q <= 1'b0;
         done_q <= 1'b0;
         rdata_q <= 8'h00;
         io_addr <= 16'h0000;
         io_wdata <= 8'h00;
         io_data_oe <= 1'b0;
         io_rd_n <= 1'b1;
         io_wr_n <= 1'b1;
      end else begin
         done_q <= 1'b0;
         case (cst)
            C_IDLE: if (cyc.req) begin
               io_addr <= cyc.addr;
               io_wdata <= cyc.wdata;
               io_data_oe <= cyc.we;
               we_q <= cyc.we;
               cst <= C_SETUP;
            end
            C_SETUP: begin
               io_wr_n <= !we_q;
               io_rd_n <= we_q;
               cnt <= STROBE_LOAD;
               cst <= C_STROBE;
            end
            C_STROBE: if (cnt == 4'h0) begin
               io_wr_n <= 1'b1;
               io_rd_n <= 1'b1;
               if (!we_q) begin
                  rdata_q <= data_s2;
               end
               cnt <= RECOV_LOAD;
               cst <= C_RECOV;
            end else begin
               cnt <= cnt - 4'h1;
            end
            C_RECOV: if (cnt == 4'h0) begin
               io_data_oe <= 1'b0;
               done_q <= 1'b1;
               cst <= C_IDLE;
            end else begin
               cnt <= cnt - 4'h1;
            end
            default: cst <= C_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: core/ecph_cyc_if.sv */
// Register cycle request and answer between controller and bus engine
`timescale 1ns/1ps
`default_nettype none
interface ecph_cyc_if;
   logic req;
   logic we;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic done;
   logic [7:0] rdata;
   modport master (output req, output we, output addr, output wdata, input done, input rdata);
   modport slave (input req, input we, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

/* File: core/ecph_fifo.sv */
// Parameterised first-in first-out queue with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ecph_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

/* File: core/ecph_host.sv */
// Host controller that runs an ECP parallel port through its registers
`timescale 1ns/1ps
`default_nettype none
module ecph_host
   import ecph_pkg::*;
#(
   parameter logic [15:0] BASE = BASE_DEF,
   parameter int DEPTH = QUEUE_DEPTH
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic start_fwd,
   input wire logic start_rev,
   input wire logic stop,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_is_cmd,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   output logic busy,
   output logic [2:0] port_mode,
   output logic [7:0] ecr_status,
   output logic [15:0] io_addr,
   output logic [7:0] io_wdata,
   output logic io_data_oe,
   input wire logic [7:0] io_data_in,
   output logic io_rd_n,
   output logic io_wr_n
);
   // Extended control word with mode in the top three bits
   function automatic logic [7:0] ecr_word(input logic [2:0] mode);
      return {mode, ECR_CTRL};
   endfunction

   // Allowed mode change
   function automatic logic mode_ok(input logic [2:0] cur, input logic [2:0] nxt);
      return (cur == MODE_SPP) || (cur == MODE_PS2) || (nxt == MODE_SPP) || (nxt == MODE_PS2);
   endfunction

   ecph_cyc_if cyc ();
   ecph_st_t st;
   ecph_st_t next_st;
   logic pend;
   logic dir;
   logic stop_req;
   logic f_out_valid;
   logic f_out_ready;
   logic [QUEUE_W-1:0] f_out_data;

   ecph_fifo #(
      .W(QUEUE_W),
      .DEPTH(DEPTH)
   ) u_queue (
      .clk(clk),
      .nrst(nrst),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data({tx_is_cmd, tx_data}),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data)
   );

   ecph_bus_cycle u_cycle (
      .clk(clk),
      .nrst(nrst),
      .cyc(cyc.slave),
      .io_addr(io_addr),
      .io_wdata(io_wdata),
      .io_data_oe(io_data_oe),
      .io_data_in(io_data_in),
      .io_rd_n(io_rd_n),
      .io_wr_n(io_wr_n)
   );

   wire done = cyc.done;
   wire ecp_ok = mode_ok(port_mode, MODE_ECP);
   wire leave_ok_mode = mode_ok(port_mode, MODE_PS2);
   wire dev_full = cyc.rdata[ECR_FULL];
   wire dev_empty = cyc.rdata[ECR_EMPTY];
   // Only leave once the device queue is drained, and in forward direction the host queue too
   wire leave_ok = stop_req && dev_empty && (dir || !f_out_valid);
   wire can_push = !dir && !dev_full && f_out_valid;
   wire can_pull = dir && !dev_empty && !rx_valid;
   wire is_write = (st == S_SET_PS2) || (st == S_SET_DCR) || (st == S_SET_ECP) || (st == S_PUSH) ||
      (st == S_LEAVE);
   wire is_read = (st == S_POLL) || (st == S_PULL);
   wire blocked = (st == S_SET_ECP) && !ecp_ok;
   // Command-tagged bytes to the command port, others to the data queue
   wire [15:0] push_ofs = f_out_data[QUEUE_W-1] ? OFS_CMDQ : OFS_FIFO;
   wire [15:0] reg_ofs = (st == S_SET_DCR) ? OFS_DCR :
      (st == S_PUSH) ? push_ofs :
      (st == S_PULL) ? OFS_FIFO : OFS_ECR;
   // Direction set with strobe and autofeed at zero, in mode 001
   wire [7:0] dcr_word = DCR_IDLE | (8'(dir) << DCR_DIR);
   wire [7:0] wr_word = (st == S_SET_PS2) ? ecr_word(MODE_PS2) :
      (st == S_SET_DCR) ? dcr_word :
      (st == S_SET_ECP) ? ecr_word(MODE_ECP) :
      (st == S_LEAVE) ? ecr_word(MODE_PS2) : f_out_data[7:0];

   assign cyc.req = (is_write || is_read) && !pend && !blocked;
   assign cyc.we = is_write;
   assign cyc.addr = BASE + reg_ofs;
   assign cyc.wdata = wr_word;
   assign f_out_ready = (st == S_PUSH) && done;
   assign busy = st != S_IDLE;

   always_comb begin
      next_st = st;
      case (st)
         S_IDLE: if (start_fwd || start_rev) begin
            next_st = S_SET_PS2;
         end
         S_SET_PS2: if (done) begin
            next_st = S_SET_DCR;
         end
         S_SET_DCR: if (done) begin
            next_st = S_SET_ECP;
         end
         S_SET_ECP: if (blocked) begin
            next_st = S_IDLE;
         end else if (done) begin
            next_st = S_POLL;
         end
         S_POLL: if (done) begin
            if (leave_ok && leave_ok_mode) begin
               next_st = S_LEAVE;
            end else if (can_push) begin
               next_st = S_PUSH;
            end else if (can_pull) begin
               next_st = S_PULL;
            end
         end
         S_PUSH: if (done) begin
            next_st = S_POLL;
         end
         S_PULL: if (done) begin
            next_st = S_POLL;
         end
         S_LEAVE: if (done) begin
            next_st = S_IDLE;
         end
         default: next_st = S_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= S_IDLE;
         pend <= 1'b0;
      end else begin
         st <= next_st;
         pend <= cyc.req || (pend && !done);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dir <= 1'b0;
         port_mode <= MODE_SPP;
      end else begin
         if (st == S_IDLE && (start_fwd || start_rev)) begin
            dir <= start_rev && !start_fwd;
         end
         if (done && (st == S_SET_PS2 || st == S_LEAVE)) begin
            port_mode <= MODE_PS2;
         end else if (done && st == S_SET_ECP) begin
            port_mode <= MODE_ECP;
         end
      end
   end

   // Stop request: a new stop wins over the clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stop_req <= 1'b0;
      end else if (stop) begin
         stop_req <= 1'b1;
      end else if ((st == S_LEAVE && done) || st == S_IDLE) begin
         stop_req <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ecr_status <= 8'h00;
      end else if (st == S_POLL && done) begin
         ecr_status <= cyc.rdata;
      end
   end

   // Reverse byte holding register, stalls reads until taken
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
      end else if (st == S_PULL && done) begin
         rx_valid <= 1'b1;
         rx_data <= cyc.rdata;
      end else if (rx_ready) begin
         rx_valid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: core/ecph_pkg.sv */
// Constants and types shared by the ECP host controller files
package ecph_pkg;
   localparam logic [15:0] BASE_DEF = 16'h0378;
   localparam logic [15:0] OFS_CMDQ = 16'h0000;
   localparam logic [15:0] OFS_DCR = 16'h0002;
   localparam logic [15:0] OFS_FIFO = 16'h0400;
   localparam logic [15:0] OFS_ECR = 16'h0402;
   localparam int ECR_FULL = 1;
   localparam int ECR_EMPTY = 0;
   localparam int DCR_DIR = 5;
   localparam logic [2:0] MODE_SPP = 3'h0;
   localparam logic [2:0] MODE_PS2 = 3'h1;
   localparam logic [2:0] MODE_PFIFO = 3'h2;
   localparam logic [2:0] MODE_ECP = 3'h3;
   // Fault interrupt off, DMA off, service flag clear
   localparam logic [4:0] ECR_CTRL = 5'h10;
   // Reverse request deasserted, strobe and autofeed 0
   localparam logic [7:0] DCR_IDLE = 8'h04;
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_STROBE_NS = 100;
   localparam int T_RECOV_NS = 50;
   localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOV_CYC = (T_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] STROBE_LOAD = 4'(STROBE_CYC - 1);
   localparam logic [3:0] RECOV_LOAD = 4'(RECOV_CYC - 1);
   localparam int QUEUE_DEPTH = 32;
   localparam int QUEUE_W = 9;
   typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_RECOV} ecph_cst_t;
   typedef enum logic [3:0] {
      S_IDLE, S_SET_PS2, S_SET_DCR, S_SET_ECP, S_POLL, S_PUSH, S_PULL, S_LEAVE
   } ecph_st_t;
endpackage

/* File: tb/ecph_dev.sv */
// Behavioural ECP port register model driven by the host controller
`timescale 1ns/1ps
`default_nettype none
module ecph_dev
   import ecph_pkg::*;
#(
   parameter logic [15:0] BASE = BASE_DEF
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic hold,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_data_oe,
   input wire logic io_rd_n,
   input wire logic io_wr_n,
   output logic [7:0] io_data_in
);
   logic [2:0] mode = MODE_SPP;
   logic [2:0] ctrl = 3'h4;
   logic dir = 1'b0;
   logic [7:0] rdv = 8'h00;
   logic [7:0] last = 8'h00;
   logic [8:0] q[$];
   logic [7:0] rsrc[$];
   logic [8:0] sent[$];
   int ovf = 0;
   // Released bus shows the inverse of the last byte
   assign io_data_in = io_data_oe ? io_wdata : (io_rd_n ? ~last : rdv);
   always @(negedge io_wr_n) begin
      if (io_addr == BASE + OFS_ECR) begin
         if (mode <= MODE_PS2 || io_wdata[7:5] <= MODE_PS2) begin
            mode = io_wdata[7:5];
         end
         ctrl = io_wdata[4:2];
         if (mode == MODE_SPP) begin
            q.delete();
         end
      end else if (io_addr == BASE + OFS_DCR) begin
         if (mode == MODE_PS2) begin
            dir = io_wdata[DCR_DIR];
         end
      end else if ((io_addr == BASE + OFS_CMDQ || io_addr == BASE + OFS_FIFO) && mode == MODE_ECP && !dir
         && q.size() < 16) begin
         q.push_back({io_addr == BASE + OFS_CMDQ, io_wdata});
      end else begin
         ovf++;
      end
   end
   always @(negedge io_rd_n) begin
      if (io_addr == BASE + OFS_ECR) begin
         rdv = {mode, ctrl, q.size() >= 16, q.size() == 0};
      end else if (io_addr == BASE + OFS_FIFO && q.size() > 0) begin
         rdv = 8'(q.pop_front());
      end else begin
         ovf++;
      end
   end
   always @(posedge io_rd_n) last = rdv;
   always @(posedge clk) begin
      if (!nrst) begin
         mode = MODE_SPP;
         dir = 1'b0;
         q.delete();
      end else if (mode == MODE_ECP && !dir && !hold && q.size() > 0) begin
         sent.push_back(q.pop_front());
      end else if (mode == MODE_ECP && dir && rsrc.size() > 0 && q.size() < 16) begin
         q.push_back({1'b0, rsrc.pop_front()});
      end
   end
endmodule
`default_nettype wire

/* File: tb/ecph_host_assertions.sv */
// Port-level checks for the ECP host controller
`timescale 1ns/1ps
`default_nettype none
module ecph_host_assertions
   import ecph_pkg::*;
#(
   parameter logic [15:0] BASE = BASE_DEF
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_data_oe,
   input wire logic io_rd_n,
   input wire logic io_wr_n,
   input wire logic [2:0] port_mode,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic [7:0] rx_data
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence strobe4(s);
      (!s)[*4] ##1 s;
   endsequence
   sequence wr_to(a);
      $fell(io_wr_n) && io_addr == a;
   endsequence
   wr_strobe_a: assert property ($fell(io_wr_n) |-> strobe4(io_wr_n))
      else $error("write strobe length wrong");
   rd_strobe_a: assert property ($fell(io_rd_n) |-> strobe4(io_rd_n))
      else $error("read strobe length wrong");
   oe_dir_a: assert property (!io_rd_n || !io_wr_n |-> io_data_oe == !io_wr_n)
      else $error("data drive wrong during strobe");
   addr_hold_a: assert property (!io_rd_n || !io_wr_n |-> $stable(io_addr) && $stable(io_wdata))
      else $error("address moved during strobe");
   dcr_setup_a: assert property (wr_to(BASE + OFS_DCR) |->
      port_mode == MODE_PS2 && io_wdata[4:0] == DCR_IDLE[4:0])
      else $error("control write outside mode 001");
   ecr_ctrl_a: assert property (wr_to(BASE + OFS_ECR) |-> io_wdata[4:0] == ECR_CTRL)
      else $error("extended control bits wrong");
   queue_mode_a: assert property (wr_to(BASE + OFS_CMDQ) or wr_to(BASE + OFS_FIFO) |->
      port_mode == MODE_ECP)
      else $error("queue write outside mode 011");
   rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("received byte not held");
endmodule
bind ecph_host ecph_host_assertions #(.BASE(BASE)) ecph_host_assertions_i (.clk(clk), .nrst(nrst),
   .io_addr(io_addr), .io_wdata(io_wdata), .io_data_oe(io_data_oe), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n),
   .port_mode(port_mode), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
`default_nettype wire

/* File: tb/ecph_host_tb.sv */
// Self-checking bench for the ECP host controller
`timescale 1ns/1ps
`default_nettype none
module ecph_host_tb;
   import ecph_pkg::*;
   logic clk = 0, nrst = 0, start_fwd = 0, start_rev = 0, stop = 0, tx_valid = 0, tx_is_cmd = 0;
   logic rx_ready = 0, hold = 1;
   logic [7:0] tx_data = 8'h00;
   logic tx_ready, rx_valid, busy, io_data_oe, io_rd_n, io_wr_n;
   logic [7:0] rx_data, ecr_status, io_wdata, io_data_in;
   logic [2:0] port_mode;
   logic [15:0] io_addr;
   logic [8:0] exp_q[$];
   int n_fail = 0, n_compared = 0;
   always #12.5 clk = ~clk;
   ecph_host #(.DEPTH(4)) ecph_host_i (.clk(clk), .nrst(nrst), .start_fwd(start_fwd), .start_rev(start_rev),
      .stop(stop), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_is_cmd(tx_is_cmd),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .busy(busy), .port_mode(port_mode),
      .ecr_status(ecr_status), .io_addr(io_addr), .io_wdata(io_wdata), .io_data_oe(io_data_oe),
      .io_data_in(io_data_in), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n));
   ecph_dev ecph_dev_i (.clk(clk), .nrst(nrst), .hold(hold), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_data_oe(io_data_oe), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_data_in(io_data_in));
   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict;
      if (n_fail == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      @(negedge clk);
      s = 0;
   endtask
   // Valid stays up between bytes for back-to-back transfers
   task automatic put(input logic [8:0] v);
      tx_valid = 1;
      {tx_is_cmd, tx_data} = v;
      exp_q.push_back(v);
      for (int i = 0; i < 3000 && tx_ready !== 1'b1; i++) @(negedge clk);
      chk("tx_ready", 9'h1, {8'h00, tx_ready});
      @(negedge clk);
   endtask
   task automatic get(input logic [7:0] e);
      for (int i = 0; i < 3000 && rx_valid !== 1'b1; i++) @(negedge clk);
      chk("rx_data", {1'b0, e}, {1'b0, rx_data});
      rx_ready = 1;
      @(negedge clk);
      rx_ready = 0;
   endtask
   task automatic idle_wait;
      for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(negedge clk);
      chk("busy", 9'h0, {8'h00, busy});
   endtask
   initial begin
      #500000;
      n_fail++;
      print_verdict();
   end
   initial begin
      repeat (5) @(negedge clk);
      nrst = 1;
      chk("strobes", 9'h3, {7'h00, io_rd_n, io_wr_n});
      chk("data oe", 9'h0, {8'h00, io_data_oe});
      chk("mode", 9'(MODE_SPP), {6'h00, port_mode});
      chk("tx_ready", 9'h1, {8'h00, tx_ready});
      pulse(start_fwd);
      for (int k = 0; k < 20; k++) put({k[1:0] == 2'h0, 8'(k * 8'h25 + 8'h03)});
      tx_valid = 0;
      repeat (600) @(negedge clk);
      chk("device fill", 9'h10, 9'(ecph_dev_i.q.size()));
      chk("mode", 9'(MODE_ECP), {6'h00, port_mode});
      hold = 0;
      pulse(stop);
      idle_wait();
      chk("ecr status", {1'b0, MODE_ECP, ECR_CTRL[4:2], 2'b01}, {1'b0, ecr_status});
      chk("sent count", 9'h14, 9'(ecph_dev_i.sent.size()));
      foreach (exp_q[k]) chk("sent byte", exp_q[k], ecph_dev_i.sent[k]);
      chk("refused", 9'h0, 9'(ecph_dev_i.ovf));
      chk("mode", 9'(MODE_PS2), {6'h00, port_mode});
      for (int k = 0; k < 5; k++) ecph_dev_i.rsrc.push_back(8'(8'ha0 + k));
      pulse(start_rev);
      repeat (100) @(negedge clk);
      for (int k = 0; k < 5; k++) get(8'(8'ha0 + k));
      pulse(stop);
      idle_wait();
      chk("direction", 9'h1, {8'h00, ecph_dev_i.dir});
      chk("refused", 9'h0, 9'(ecph_dev_i.ovf));
      print_verdict();
   end
endmodule
`default_nettype wire
